// ==== hw/uwcir_regs.sv ====
/*
 * control and interrupt register bank wrapped around a usb controller core.
 * assumes one clock, an asynchronous active-low reset, and a register
 * master that uses single-cycle read/write strobes with read data one
 * cycle later; core interrupt events arrive as one-cycle pulses.
 */
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ns

module uwcir_regs #(
	parameter int SOFT_RESET_LEN = uwcir_pkg::SOFT_RESET_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	// usb core side
	input wire logic bus_power_drive_i,
	input wire logic [8:0] core_evt_i,
	input wire logic [4:0] rx_evt_i,
	input wire logic [4:0] tx_evt_i,
	output logic core_soft_reset_o,
	output logic clock_stop_quick_ack_o,
	output logic network_framing_mode_o,
	output logic [3:0] rx_framing_en_o,
	output logic [3:0] tx_framing_en_o,
	output logic [7:0] auto_request_o,
	// interrupt to cpu
	output logic irq_o
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic [31:0] pack_irq(input uwcir_pkg::uwcir_irq_t v);
		return {7'h00, v.core, 3'h0, v.rx, 3'h0, v.tx};
	endfunction

	function automatic uwcir_pkg::uwcir_irq_t unpack_irq(input logic [31:0] w);
		uwcir_pkg::uwcir_irq_t v;
		v.core = w[24:16];
		v.rx = w[12:8];
		v.tx = w[4:0];
		return v;
	endfunction

	// reserved code 2 is driven to the core side as off
	function automatic logic [1:0] areq_legal(input logic [1:0] c);
		return (c == 2'(uwcir_pkg::UWCIR_AREQ_RESERVED)) ? 2'(uwcir_pkg::UWCIR_AREQ_OFF) : c;
	endfunction

	uwcir_pkg::uwcir_req_t req;
	assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

	logic wr_ctl, wr_frm, wr_areq, wr_set, wr_clr, wr_mset, wr_mclr, wr_mask;
	assign wr_ctl = req.wr && hit(req.addr, uwcir_pkg::OFS_MODULE_CONTROL);
	assign wr_frm = req.wr && hit(req.addr, uwcir_pkg::OFS_ENDPOINT_FRAMING_ENABLE);
	assign wr_areq = req.wr && hit(req.addr, uwcir_pkg::OFS_AUTO_REQUEST_SELECT);
	assign wr_set = req.wr && hit(req.addr, uwcir_pkg::OFS_INTERRUPT_SOURCE_SET);
	assign wr_clr = req.wr && hit(req.addr, uwcir_pkg::OFS_INTERRUPT_SOURCE_CLEAR);
	assign wr_mask = req.wr && hit(req.addr, uwcir_pkg::OFS_INTERRUPT_MASK);
	assign wr_mset = req.wr && hit(req.addr, uwcir_pkg::OFS_INTERRUPT_MASK_SET);
	assign wr_mclr = req.wr && hit(req.addr, uwcir_pkg::OFS_INTERRUPT_MASK_CLEAR);

	// ------------------------------------------------------------
	// control register and soft reset sequencer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		UWCIR_RST_IDLE = 2'b01,
		UWCIR_RST_BUSY = 2'b10
	} uwcir_rst_state_t;

	uwcir_rst_state_t rst_state_r;
	logic [15:0] rst_cnt_r;
	logic [31:0] ctl_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_state_r <= UWCIR_RST_IDLE;
			rst_cnt_r <= 16'h0000;
		end else begin
			case (rst_state_r)
				UWCIR_RST_IDLE: begin
					if (wr_ctl && req.wdata[uwcir_pkg::CTL_SOFT_RESET_BIT]) begin
						rst_state_r <= UWCIR_RST_BUSY;
						rst_cnt_r <= 16'(SOFT_RESET_LEN - 1);
					end
				end
				UWCIR_RST_BUSY: begin
					if (rst_cnt_r == 16'h0000) begin
						rst_state_r <= UWCIR_RST_IDLE;
					end else begin
						rst_cnt_r <= rst_cnt_r - 16'h0001;
					end
				end
				default: begin
					rst_state_r <= UWCIR_RST_IDLE;
				end
			endcase
		end
	end

	logic soft_rst;
	assign soft_rst = (rst_state_r == UWCIR_RST_BUSY);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl_r <= uwcir_pkg::CTL_RESET;
		end else if (wr_ctl) begin
			ctl_r <= req.wdata & uwcir_pkg::CTL_RW_MASK;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_soft_reset_o <= 1'b0;
		end else begin
			core_soft_reset_o <= soft_rst;
		end
	end

	// ------------------------------------------------------------
	// framing and auto-request registers
	// ------------------------------------------------------------
	logic [31:0] frm_r, areq_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frm_r <= uwcir_pkg::FRM_RESET;
		end else if (wr_frm) begin
			frm_r <= req.wdata & uwcir_pkg::FRM_RW_MASK;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			areq_r <= uwcir_pkg::AREQ_RESET;
		end else if (wr_areq) begin
			areq_r <= req.wdata & uwcir_pkg::AREQ_RW_MASK;
		end
	end

	uwcir_pkg::uwcir_cfg_t cfg_nxt;
	always_comb begin
		cfg_nxt.network_framing_mode = ctl_r[uwcir_pkg::CTL_NETWORK_FRAMING_MODE_BIT];
		cfg_nxt.core_irq_path_enable = ctl_r[uwcir_pkg::CTL_CORE_IRQ_PATH_ENABLE_BIT];
		cfg_nxt.clock_stop_quick_ack = ctl_r[uwcir_pkg::CTL_CLOCK_STOP_QUICK_ACK_BIT];
		cfg_nxt.rx_framing_en = frm_r[uwcir_pkg::FRM_RX_LSB +: uwcir_pkg::EP_COUNT];
		cfg_nxt.tx_framing_en = frm_r[uwcir_pkg::FRM_TX_LSB +: uwcir_pkg::EP_COUNT];
		for (int i = 0; i < uwcir_pkg::EP_COUNT; i++) begin
			cfg_nxt.auto_request[2*i +: 2] = areq_legal(areq_r[2*i +: 2]);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			network_framing_mode_o <= 1'b0;
			clock_stop_quick_ack_o <= 1'b0;
			rx_framing_en_o <= 4'h0;
			tx_framing_en_o <= 4'h0;
			auto_request_o <= 8'h00;
		end else begin
			network_framing_mode_o <= cfg_nxt.network_framing_mode;
			clock_stop_quick_ack_o <= cfg_nxt.clock_stop_quick_ack;
			rx_framing_en_o <= cfg_nxt.rx_framing_en;
			tx_framing_en_o <= cfg_nxt.tx_framing_en;
			auto_request_o <= cfg_nxt.auto_request;
		end
	end

	// ------------------------------------------------------------
	// interrupt sources and mask
	// ------------------------------------------------------------
	logic [31:0] src_r, mask_r, hw_evt, sw_set, sw_clr;
	assign hw_evt = pack_irq('{core: core_evt_i, rx: rx_evt_i, tx: tx_evt_i});
	assign sw_set = wr_set ? (req.wdata & uwcir_pkg::INT_FIELD_MASK) : 32'h0000_0000;
	assign sw_clr = wr_clr ? (req.wdata & uwcir_pkg::INT_FIELD_MASK) : 32'h0000_0000;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_r <= uwcir_pkg::INT_SRC_RESET;
		end else if (soft_rst) begin
			src_r <= uwcir_pkg::INT_SRC_RESET;
		end else begin
			// forced and hardware events share one path, and both beat a clear
			src_r <= (src_r & ~sw_clr) | hw_evt | sw_set;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_r <= uwcir_pkg::INT_MASK_RESET;
		end else if (wr_mask) begin
			mask_r <= req.wdata & uwcir_pkg::INT_FIELD_MASK;
		end else if (wr_mset) begin
			mask_r <= mask_r | (req.wdata & uwcir_pkg::INT_FIELD_MASK);
		end else if (wr_mclr) begin
			mask_r <= mask_r & ~req.wdata;
		end
	end

	logic [31:0] masked;
	assign masked = src_r & mask_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= ctl_r[uwcir_pkg::CTL_CORE_IRQ_PATH_ENABLE_BIT] && (|masked);
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (req.rd) begin
			case (req.addr)
				uwcir_pkg::OFS_MODULE_CONTROL: begin
					reg_rdata_o <= ctl_r | {31'h0000_0000, soft_rst};
				end
				uwcir_pkg::OFS_MODULE_STATUS: begin
					reg_rdata_o <= {31'h0000_0000, bus_power_drive_i};
				end
				uwcir_pkg::OFS_ENDPOINT_FRAMING_ENABLE: begin
					reg_rdata_o <= frm_r;
				end
				uwcir_pkg::OFS_AUTO_REQUEST_SELECT: begin
					reg_rdata_o <= areq_r;
				end
				uwcir_pkg::OFS_INTERRUPT_SOURCE: begin
					reg_rdata_o <= src_r;
				end
				uwcir_pkg::OFS_INTERRUPT_MASK: begin
					reg_rdata_o <= mask_r;
				end
				uwcir_pkg::OFS_MASKED_INTERRUPT: begin
					reg_rdata_o <= masked;
				end
				default: begin
					// write-only and unmapped addresses read zero
					reg_rdata_o <= 32'h0000_0000;
				end
			endcase
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

endmodule

// ==== hw/uwcir_pkg.sv ====
/*
 * package for the wrapper control and interrupt register bank:
 * register offsets, field positions, reset values and carrier types.
 * assumes a single 125 MHz clock and a plain strobe register port.
 */
package uwcir_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_MODULE_CONTROL = 8'h04;
	localparam logic [7:0] OFS_MODULE_STATUS = 8'h08;
	localparam logic [7:0] OFS_ENDPOINT_FRAMING_ENABLE = 8'h10;
	localparam logic [7:0] OFS_AUTO_REQUEST_SELECT = 8'h14;
	localparam logic [7:0] OFS_INTERRUPT_SOURCE = 8'h20;
	localparam logic [7:0] OFS_INTERRUPT_SOURCE_SET = 8'h24;
	localparam logic [7:0] OFS_INTERRUPT_SOURCE_CLEAR = 8'h28;
	localparam logic [7:0] OFS_INTERRUPT_MASK = 8'h2c;
	localparam logic [7:0] OFS_INTERRUPT_MASK_SET = 8'h30;
	localparam logic [7:0] OFS_INTERRUPT_MASK_CLEAR = 8'h34;
	localparam logic [7:0] OFS_MASKED_INTERRUPT = 8'h38;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTL_SOFT_RESET_BIT = 0;
	localparam int CTL_CLOCK_STOP_QUICK_ACK_BIT = 1;
	localparam int CTL_CORE_IRQ_PATH_ENABLE_BIT = 3;
	localparam int CTL_NETWORK_FRAMING_MODE_BIT = 4;
	localparam int STS_BUS_POWER_DRIVE_BIT = 0;
	localparam int FRM_TX_LSB = 0;
	localparam int FRM_RX_LSB = 16;
	localparam int EP_COUNT = 4;

	// writable / live bits of each register
	localparam logic [31:0] CTL_RW_MASK = 32'h0000_001a;
	localparam logic [31:0] FRM_RW_MASK = 32'h000f_000f;
	localparam logic [31:0] AREQ_RW_MASK = 32'h0000_00ff;
	localparam logic [31:0] INT_FIELD_MASK = 32'h01ff_1f1f;

	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam logic [31:0] CTL_RESET = 32'h0000_0000;
	localparam logic [31:0] FRM_RESET = 32'h0000_0000;
	localparam logic [31:0] AREQ_RESET = 32'h0000_0000;
	localparam logic [31:0] INT_SRC_RESET = 32'h0000_0000;
	localparam logic [31:0] INT_MASK_RESET = 32'h0000_0000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SOFT_RESET_NS = 64;
	localparam int SOFT_RESET_CYCLES =
		(SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// auto-request encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		UWCIR_AREQ_OFF = 2'h0,
		UWCIR_AREQ_ALL_BUT_EOP = 2'h1,
		UWCIR_AREQ_RESERVED = 2'h2,
		UWCIR_AREQ_ALWAYS = 2'h3
	} uwcir_areq_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} uwcir_req_t;

	typedef struct packed {
		logic [8:0] core;
		logic [4:0] rx;
		logic [4:0] tx;
	} uwcir_irq_t;

	typedef struct packed {
		logic network_framing_mode;
		logic core_irq_path_enable;
		logic clock_stop_quick_ack;
		logic [3:0] rx_framing_en;
		logic [3:0] tx_framing_en;
		logic [7:0] auto_request;
	} uwcir_cfg_t;

endpackage

// ==== tb/uwcir_regs_chk.sv ====
/*
 * port checker for the control and interrupt register bank.
 * assumes it is bound to uwcir_regs and sees only its ports.
 */
`timescale 1ns/1ns
module uwcir_regs_chk #(
	parameter int SOFT_RESET_LEN = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [31:0] reg_rdata_o,
	// core side
	input wire logic bus_power_drive_i,
	input wire logic core_soft_reset_o,
	input wire logic [7:0] auto_request_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic ctl3_r;
	logic [7:0] srst_cnt_r;
	// ------------------------------------------------------------
	// shadow of the interrupt enable and soft reset length
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ctl3_r <= 1'b0;
		else if (reg_wr_i && reg_addr_i == uwcir_pkg::OFS_MODULE_CONTROL)
			ctl3_r <= reg_wdata_i[3];
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			srst_cnt_r <= 8'h00;
		else
			srst_cnt_r <= core_soft_reset_o ? srst_cnt_r + 8'h01 : 8'h00;
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	AST_RDATA_IDLE:
	assert property (!reg_rd_i |=> reg_rdata_o == 32'h0) else $error("read data not idle");
	AST_STATUS_LIVE:
	assert property ((reg_rd_i && reg_addr_i == uwcir_pkg::OFS_MODULE_STATUS)
		|=> reg_rdata_o == {31'h0, $past(bus_power_drive_i)}) else $error("status wrong");
	AST_CTL_RSVD:
	assert property ((reg_rd_i && reg_addr_i == uwcir_pkg::OFS_MODULE_CONTROL)
		|=> (reg_rdata_o & ~32'h0000_001b) == 32'h0) else $error("control reserved set");
	AST_FRM_RSVD:
	assert property ((reg_rd_i && reg_addr_i == uwcir_pkg::OFS_ENDPOINT_FRAMING_ENABLE)
		|=> (reg_rdata_o & ~uwcir_pkg::FRM_RW_MASK) == 32'h0) else $error("framing reserved");
	AST_SRC_RSVD:
	assert property ((reg_rd_i && reg_addr_i == uwcir_pkg::OFS_INTERRUPT_SOURCE)
		|=> (reg_rdata_o & ~uwcir_pkg::INT_FIELD_MASK) == 32'h0) else $error("source reserved");
	AST_SET_READS_ZERO:
	assert property ((reg_rd_i && reg_addr_i == uwcir_pkg::OFS_INTERRUPT_SOURCE_SET)
		|=> reg_rdata_o == 32'h0) else $error("set register reads nonzero");
	AST_AREQ_NO_RSVD:
	assert property (auto_request_o[1:0] != 2'h2 && auto_request_o[3:2] != 2'h2
		&& auto_request_o[5:4] != 2'h2 && auto_request_o[7:6] != 2'h2)
		else $error("reserved auto request code at core");
	AST_IRQ_GATE:
	assert property ((!ctl3_r && !$past(ctl3_r)) |-> !irq_o) else $error("irq while disabled");
	AST_SRST_START:
	assert property ((reg_wr_i && reg_addr_i == uwcir_pkg::OFS_MODULE_CONTROL
		&& reg_wdata_i[0] && !core_soft_reset_o) |-> ##2 core_soft_reset_o)
		else $error("soft reset not started");
	AST_SRST_LEN:
	assert property (srst_cnt_r <= SOFT_RESET_LEN) else $error("soft reset too long");
	AST_SRST_EXACT:
	assert property ($fell(core_soft_reset_o) |-> srst_cnt_r == SOFT_RESET_LEN)
		else $error("soft reset length wrong");
endmodule
bind uwcir_regs uwcir_regs_chk #(.SOFT_RESET_LEN(SOFT_RESET_LEN)) u_chk (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.bus_power_drive_i(bus_power_drive_i), .core_soft_reset_o(core_soft_reset_o),
	.auto_request_o(auto_request_o), .irq_o(irq_o));

// ==== tb/uwcir_regs_tb.sv ====
/*
 * testbench for the control and interrupt register bank.
 * assumes the package and design are compiled first.
 */
`timescale 1ns/1ns
module uwcir_regs_tb;
	logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, bus_power_drive_i;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	uwcir_pkg::uwcir_irq_t evt;
	logic core_soft_reset_o, clock_stop_quick_ack_o, network_framing_mode_o, irq_o;
	logic [3:0] rx_framing_en_o, tx_framing_en_o;
	logic [7:0] auto_request_o;
	logic [1:0] code;
	int num_errors, checks_done;

	uwcir_regs #(.SOFT_RESET_LEN(2)) DUT (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.bus_power_drive_i(bus_power_drive_i), .core_evt_i(evt.core), .rx_evt_i(evt.rx),
		.tx_evt_i(evt.tx), .core_soft_reset_o(core_soft_reset_o),
		.clock_stop_quick_ack_o(clock_stop_quick_ack_o),
		.network_framing_mode_o(network_framing_mode_o), .rx_framing_en_o(rx_framing_en_o),
		.tx_framing_en_o(tx_framing_en_o), .auto_request_o(auto_request_o), .irq_o(irq_o));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task automatic check(string n, logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d, uwcir_pkg::uwcir_irq_t e = '0);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		evt <= e;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		evt <= '0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] exp);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		check($sformatf("read %h", a), reg_rdata_o, exp);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		wrap_up();
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		rst_n_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		bus_power_drive_i = 1'b0;
		evt = '0;
		num_errors = 0;
		checks_done = 0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(uwcir_pkg::OFS_MODULE_CONTROL, 32'h0);
		rd(uwcir_pkg::OFS_MODULE_STATUS, 32'h0);
		rd(uwcir_pkg::OFS_ENDPOINT_FRAMING_ENABLE, 32'h0);
		rd(uwcir_pkg::OFS_AUTO_REQUEST_SELECT, 32'h0);
		rd(uwcir_pkg::OFS_INTERRUPT_SOURCE, 32'h0);
		wr(uwcir_pkg::OFS_MODULE_CONTROL, 32'hffff_fffe);
		rd(uwcir_pkg::OFS_MODULE_CONTROL, 32'h0000_001a);
		check("quick ack", {31'h0, clock_stop_quick_ack_o}, 32'h1);
		check("framing mode", {31'h0, network_framing_mode_o}, 32'h1);
		wr(uwcir_pkg::OFS_ENDPOINT_FRAMING_ENABLE, 32'hffff_ffff);
		rd(uwcir_pkg::OFS_ENDPOINT_FRAMING_ENABLE, 32'h000f_000f);
		wr(uwcir_pkg::OFS_ENDPOINT_FRAMING_ENABLE, 32'h0008_0001);
		rd(uwcir_pkg::OFS_ENDPOINT_FRAMING_ENABLE, 32'h0008_0001);
		check("ep framing", {24'h0, rx_framing_en_o, tx_framing_en_o}, 32'h81);
		@(posedge clk_i);
		bus_power_drive_i <= 1'b1;
		rd(uwcir_pkg::OFS_MODULE_STATUS, 32'h1);
		@(posedge clk_i);
		bus_power_drive_i <= 1'b0;
		rd(uwcir_pkg::OFS_MODULE_STATUS, 32'h0);
		for (int c = 0; c < 4; c++) begin
			code = c[1:0];
			wr(uwcir_pkg::OFS_AUTO_REQUEST_SELECT, {24'hff_ffff, {4{code}}});
			rd(uwcir_pkg::OFS_AUTO_REQUEST_SELECT, {24'h0, {4{code}}});
			check("areq out", {24'h0, auto_request_o},
				(code == 2'h2) ? 32'h0 : {24'h0, {4{code}}});
		end
		wr(uwcir_pkg::OFS_INTERRUPT_MASK, 32'hffff_ffff);
		rd(uwcir_pkg::OFS_INTERRUPT_MASK, uwcir_pkg::INT_FIELD_MASK);
		wr(uwcir_pkg::OFS_INTERRUPT_SOURCE_SET, 32'hffff_ffff);
		rd(uwcir_pkg::OFS_INTERRUPT_SOURCE, 32'h01ff_1f1f);
		rd(uwcir_pkg::OFS_INTERRUPT_SOURCE_SET, 32'h0);
		check("irq forced", {31'h0, irq_o}, 32'h1);
		rd(uwcir_pkg::OFS_MASKED_INTERRUPT, 32'h01ff_1f1f);
		wr(uwcir_pkg::OFS_INTERRUPT_SOURCE_CLEAR, 32'h01ff_1f1f);
		rd(uwcir_pkg::OFS_INTERRUPT_SOURCE, 32'h0);
		check("irq cleared", {31'h0, irq_o}, 32'h0);
		wr(uwcir_pkg::OFS_INTERRUPT_SOURCE_CLEAR, 32'h0001_0000, '{9'h001, 5'h10, 5'h01});
		rd(uwcir_pkg::OFS_INTERRUPT_SOURCE, 32'h0001_1001);
		check("irq hw", {31'h0, irq_o}, 32'h1);
		wr(uwcir_pkg::OFS_INTERRUPT_MASK_CLEAR, 32'hffff_ffff);
		rd(uwcir_pkg::OFS_MASKED_INTERRUPT, 32'h0);
		check("irq masked", {31'h0, irq_o}, 32'h0);
		wr(uwcir_pkg::OFS_INTERRUPT_MASK_SET, 32'h0000_0001);
		rd(uwcir_pkg::OFS_MASKED_INTERRUPT, 32'h1);
		check("irq unmasked", {31'h0, irq_o}, 32'h1);
		wr(uwcir_pkg::OFS_MODULE_CONTROL, 32'h0);
		rd(uwcir_pkg::OFS_MODULE_CONTROL, 32'h0);
		check("irq disabled", {31'h0, irq_o}, 32'h0);
		wr(uwcir_pkg::OFS_MODULE_CONTROL, 32'h0000_0009);
		rd(uwcir_pkg::OFS_MODULE_CONTROL, 32'h0000_0009);
		check("soft reset out", {31'h0, core_soft_reset_o}, 32'h1);
		repeat (10) @(posedge clk_i);
		rd(uwcir_pkg::OFS_MODULE_CONTROL, 32'h0000_0008);
		check("soft reset done", {31'h0, core_soft_reset_o}, 32'h0);
		rd(uwcir_pkg::OFS_INTERRUPT_SOURCE, 32'h0);
		rd(uwcir_pkg::OFS_ENDPOINT_FRAMING_ENABLE, 32'h0008_0001);
		rd(8'h3c, 32'h0);
		rd(uwcir_pkg::OFS_INTERRUPT_SOURCE_CLEAR, 32'h0);
		wrap_up();
	end
endmodule
